// file: hw/sdp_pkg.sv
package sdp_pkg;
  // drive state of the two bridge channels
  typedef enum logic [1:0] {
    SDP_ST_STANDBY,
    SDP_ST_BOOST,
    SDP_ST_RUN,
    SDP_ST_THERMAL
  } sdp_state_type;

  // timing
  localparam int SDP_CLK_HZ = 100_000_000;
  localparam int SDP_BOOST_SETTLE_US = 1000;
  localparam int SDP_BOOST_SETTLE_CYC = SDP_BOOST_SETTLE_US * (SDP_CLK_HZ / 1_000_000);

  // excitation level codes, signed percent
  localparam logic signed [7:0] SDP_LEVEL_POS_FULL = 8'sh64;
  localparam logic signed [7:0] SDP_LEVEL_NEG_FULL = -8'sh64;
  localparam logic signed [7:0] SDP_LEVEL_OFF = 8'sh00;

  // full-step position index after standby release
  localparam logic [1:0] SDP_POS_INIT = 2'h0;
  localparam int SDP_CHANNELS = 2;
endpackage

// file: hw/sdp_fault_if.sv
// per-channel fault view shared between top and fault latch
interface sdp_fault_if #(parameter int CHANNELS = 2);
  logic [CHANNELS-1:0] short_raw;
  logic [CHANNELS-1:0] sense_open;
  logic [CHANNELS-1:0] chan_off;
  logic drive_type_select;
  logic chip_active;
  modport latch (input short_raw, input sense_open, input drive_type_select, input chip_active,
    output chan_off);
  modport top (output short_raw, output sense_open, output drive_type_select, output chip_active,
    input chan_off);
endinterface

// file: hw/sdp_short_latch.sv
module sdp_short_latch #(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fault view
  sdp_fault_if.latch flt
);
  import sdp_pkg::*;

  logic [CHANNELS-1:0] latched_r;
  logic [CHANNELS-1:0] latched_nxt;
  logic [CHANNELS-1:0] trip;
  logic any_trip;

  // open sense node counts as a short on that channel
  assign trip = flt.short_raw | flt.sense_open;
  assign any_trip = |(trip | latched_r);
  // stepper mode groups channels, dc mode keeps them apart
  assign latched_nxt = !flt.chip_active ? '0 :
    (flt.drive_type_select ? (latched_r | trip)
                           : (any_trip ? '1 : latched_r));
  assign flt.chan_off = latched_r;

  // latch held until chip_active drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latched_r <= '0;
    end else begin
      latched_r <= latched_nxt;
    end
  end
endmodule

// file: hw/sdp_top.sv
// Functional notes
// - efficiency_mode_enable high selects automatic current adjusting drive.
// - step-out only evaluated in high-efficiency mode, never in normal mode.
// - step-out pulls step_out_flag_n low from detection until the next step rise or until HIGH_EFFICIENCY falls.
// - output short latches the affected channel outputs off and asserts the warning output.
// - stepper mode: a short on either channel stands by both channels.
// - dc mode: short protection acts per channel, other keeps running.
// - open current_sense_node is treated as a short on that channel.
// - boost pump runs only with chip_active; outputs off until rail is ready.
// - logic_regulator enabled only with motor supply and chip_active.
// - thermal_trip turns all outputs off and asserts warning together.
// - drive resumes by itself once thermal_trip clears (hysteresis).
// - leaving standby sets channels to +100% and -100% full-step position.
// - unconnected logic inputs read low via internal pull-down.
module sdp_top
  import sdp_pkg::*;
#(
  parameter int BOOST_SETTLE_CYC = sdp_pkg::SDP_BOOST_SETTLE_CYC
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // host controls
  input wire logic CHIP_ACTIVE,
  input wire logic DRIVE_TYPE_SELECT,
  input wire logic EFFICIENCY_MODE_ENABLE,
  input wire logic STEP,
  // analog monitors, digitised
  input wire logic MOTOR_SUPPLY_OK,
  input wire logic GATE_BOOST_RAIL_OK,
  input wire logic THERMAL_TRIP,
  input wire logic STEP_OUT_DETECT,
  input wire logic [1:0] SHORT_DETECT,
  input wire logic [1:0] CURRENT_SENSE_NODE_OPEN,
  // supply control
  output logic CHARGE_PUMP_EN,
  output logic LOGIC_REGULATOR_EN,
  // channel drive
  output logic [1:0] CHAN_ENABLE,
  output logic signed [7:0] CHAN1_LEVEL,
  output logic signed [7:0] CHAN2_LEVEL,
  output logic [1:0] EXCITE_POS,
  output logic HIGH_EFFICIENCY,
  output logic BOOST_READY,
  // open-drain flags, oe low drives low
  output logic STEP_OUT_FLAG_N_O,
  output logic STEP_OUT_FLAG_N_OE_N,
  output logic WARNING_N_O,
  output logic WARNING_N_OE_N
);
  import sdp_pkg::*;

  initial begin
    if (BOOST_SETTLE_CYC < 1) begin
      $error("boost settle count must be positive");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning

  // a floating pin arrives here as 0 or X; X is treated as low
  function automatic logic pin_level(input logic v);
    pin_level = (v === 1'b1);
  endfunction

  wire chip_active = pin_level(CHIP_ACTIVE);
  wire drive_type_select = pin_level(DRIVE_TYPE_SELECT);
  wire efficiency_mode_enable = pin_level(EFFICIENCY_MODE_ENABLE);
  wire step_in = pin_level(STEP);

  ////////////////////////////////////////////////////////////////////////////
  // fault latch

  sdp_fault_if #(.CHANNELS(SDP_CHANNELS)) flt ();
  assign flt.short_raw = SHORT_DETECT;
  assign flt.sense_open = CURRENT_SENSE_NODE_OPEN;
  assign flt.drive_type_select = drive_type_select;
  assign flt.chip_active = chip_active;

  sdp_short_latch #(.CHANNELS(SDP_CHANNELS)) u_latch (
    .clk(MCLK),
    .rst_n(RESETN),
    .flt(flt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // supply sequencing

  assign CHARGE_PUMP_EN = chip_active;
  assign LOGIC_REGULATOR_EN = chip_active & MOTOR_SUPPLY_OK;

  // settle counter from chip_active rise; visible to host as BOOST_READY
  logic [31:0] settle_cnt_r;
  logic [31:0] settle_cnt_nxt;
  wire settle_done = (settle_cnt_r >= 32'(BOOST_SETTLE_CYC));
  assign settle_cnt_nxt = !chip_active ? 32'h0 : (settle_done ? settle_cnt_r : settle_cnt_r + 32'h1);

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      settle_cnt_r <= 32'h0;
    end else begin
      settle_cnt_r <= settle_cnt_nxt;
    end
  end
  assign BOOST_READY = settle_done;

  ////////////////////////////////////////////////////////////////////////////
  // state machine

  sdp_state_type state_r;
  sdp_state_type state_nxt;
  wire rail_ok = GATE_BOOST_RAIL_OK & LOGIC_REGULATOR_EN;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SDP_ST_STANDBY: begin
        if (chip_active) begin
          state_nxt = SDP_ST_BOOST;
        end
      end
      SDP_ST_BOOST: begin
        if (!chip_active) begin
          state_nxt = SDP_ST_STANDBY;
        end else if (rail_ok) begin
          state_nxt = SDP_ST_RUN;
        end
      end
      SDP_ST_RUN: begin
        if (!chip_active) begin
          state_nxt = SDP_ST_STANDBY;
        end else if (THERMAL_TRIP) begin
          state_nxt = SDP_ST_THERMAL;
        end else if (!rail_ok) begin
          state_nxt = SDP_ST_BOOST;
        end
      end
      SDP_ST_THERMAL: begin
        if (!chip_active) begin
          state_nxt = SDP_ST_STANDBY;
        end else if (!THERMAL_TRIP) begin
          state_nxt = SDP_ST_BOOST;
        end
      end
      default: begin
        state_nxt = SDP_ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= SDP_ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // excitation position

  logic step_d_r;
  logic [1:0] pos_r;
  logic [1:0] pos_nxt;
  wire step_rise = step_in & ~step_d_r;
  wire running = (state_r == SDP_ST_RUN);
  wire leaving_standby = (state_r == SDP_ST_STANDBY) & chip_active;

  assign pos_nxt = leaving_standby ? SDP_POS_INIT :
    ((running & step_rise) ? pos_r + 2'h1 : pos_r);

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      step_d_r <= 1'b0;
      pos_r <= SDP_POS_INIT;
    end else begin
      step_d_r <= step_in;
      pos_r <= pos_nxt;
    end
  end

  // full-step table: pos 0 is (+100, -100)
  function automatic logic signed [7:0] level_of(input logic [1:0] p, input logic ch2);
    logic [1:0] q;
    q = ch2 ? p + 2'h1 : p;
    level_of = q[1] ? SDP_LEVEL_NEG_FULL : SDP_LEVEL_POS_FULL;
    if (ch2) begin
      level_of = -level_of;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // channel outputs

  // thermal trip gates the outputs directly so off and warning land together
  wire [1:0] chan_on_nxt = {2{running & ~THERMAL_TRIP}} & ~flt.chan_off;
  logic [1:0] chan_on_r;
  logic signed [7:0] lvl1_r;
  logic signed [7:0] lvl2_r;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      chan_on_r <= 2'h0;
      lvl1_r <= SDP_LEVEL_OFF;
      lvl2_r <= SDP_LEVEL_OFF;
    end else begin
      chan_on_r <= chan_on_nxt;
      lvl1_r <= chan_on_nxt[0] ? level_of(pos_nxt, 1'b0) : SDP_LEVEL_OFF;
      lvl2_r <= chan_on_nxt[1] ? level_of(pos_nxt, 1'b1) : SDP_LEVEL_OFF;
    end
  end
  assign CHAN_ENABLE = chan_on_r;
  assign CHAN1_LEVEL = lvl1_r;
  assign CHAN2_LEVEL = lvl2_r;
  assign EXCITE_POS = pos_r;
  assign HIGH_EFFICIENCY = efficiency_mode_enable & running;

  ////////////////////////////////////////////////////////////////////////////
  // step-out flag: low from detection until next step rise or HIGH_EFFICIENCY falls

  logic step_out_r;
  wire step_out_eval = STEP_OUT_DETECT & HIGH_EFFICIENCY;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      step_out_r <= 1'b0;
    end else if (step_out_eval & ~step_out_r) begin
      step_out_r <= 1'b1;
    end else if (step_rise | ~HIGH_EFFICIENCY) begin
      step_out_r <= 1'b0;
    end
  end

  // warning flag: any short latch or thermal shutdown
  logic warn_r;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      warn_r <= 1'b0;
    end else begin
      warn_r <= (|flt.chan_off) | THERMAL_TRIP;
    end
  end

  assign STEP_OUT_FLAG_N_O = 1'b0;
  assign STEP_OUT_FLAG_N_OE_N = ~step_out_r;
  assign WARNING_N_O = 1'b0;
  assign WARNING_N_OE_N = ~warn_r;
endmodule

// file: verification/sdp_top_asserts.sv
module sdp_top_checker (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESETN,
  // inputs
  input wire logic CHIP_ACTIVE,
  input wire logic DRIVE_TYPE_SELECT,
  input wire logic EFFICIENCY_MODE_ENABLE,
  input wire logic STEP,
  input wire logic MOTOR_SUPPLY_OK,
  input wire logic THERMAL_TRIP,
  input wire logic STEP_OUT_DETECT,
  input wire logic [1:0] SHORT_DETECT,
  input wire logic [1:0] CURRENT_SENSE_NODE_OPEN,
  // outputs
  input wire logic CHARGE_PUMP_EN,
  input wire logic LOGIC_REGULATOR_EN,
  input wire logic [1:0] CHAN_ENABLE,
  input wire logic HIGH_EFFICIENCY,
  input wire logic STEP_OUT_FLAG_N_OE_N,
  input wire logic WARNING_N_OE_N
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RESETN);
  ////////////////////////////////////////////////////////////
  // supplies, modes and flags
  a_pump_follows: assert property (CHARGE_PUMP_EN == CHIP_ACTIVE)
    else $error("pump wrong");
  a_reg_needs_supply: assert property (LOGIC_REGULATOR_EN == (CHIP_ACTIVE && MOTOR_SUPPLY_OK))
    else $error("regulator wrong");
  a_eff_needs_enable: assert property (HIGH_EFFICIENCY |-> EFFICIENCY_MODE_ENABLE)
    else $error("efficiency wrong");
  a_flag_needs_eff: assert property ($fell(STEP_OUT_FLAG_N_OE_N) |-> $past(HIGH_EFFICIENCY) && $past(STEP_OUT_DETECT))
    else $error("flag cause");
  a_flag_holds: assert property (!STEP [*4] ##0 (!STEP_OUT_FLAG_N_OE_N && HIGH_EFFICIENCY) |=> !STEP_OUT_FLAG_N_OE_N)
    else $error("flag early");
  a_short_grouped: assert property ((CHIP_ACTIVE && !DRIVE_TYPE_SELECT && SHORT_DETECT != 2'h0)
    ##1 (CHIP_ACTIVE && !DRIVE_TYPE_SELECT) [*2] |=> CHAN_ENABLE == 2'h0 && !WARNING_N_OE_N)
    else $error("short grouping");
  a_short_per_chan: assert property ((CHIP_ACTIVE && DRIVE_TYPE_SELECT
    && (SHORT_DETECT[0] || CURRENT_SENSE_NODE_OPEN[0])) ##1 (CHIP_ACTIVE && DRIVE_TYPE_SELECT) [*2] |=> !CHAN_ENABLE[0])
    else $error("short channel");
  a_thermal_off: assert property ((THERMAL_TRIP && CHIP_ACTIVE) [*2] |-> CHAN_ENABLE == 2'h0 && !WARNING_N_OE_N)
    else $error("thermal");
  // main scenarios
  c_flag: cover property ($fell(STEP_OUT_FLAG_N_OE_N));
  c_warn: cover property ($fell(WARNING_N_OE_N));
  c_run: cover property ($rose(CHAN_ENABLE[1]));
endmodule
bind sdp_top sdp_top_checker sdp_top_checker_inst (.MCLK, .RESETN, .CHIP_ACTIVE, .DRIVE_TYPE_SELECT,
  .EFFICIENCY_MODE_ENABLE, .STEP, .MOTOR_SUPPLY_OK, .THERMAL_TRIP, .STEP_OUT_DETECT, .SHORT_DETECT,
  .CURRENT_SENSE_NODE_OPEN, .CHARGE_PUMP_EN, .LOGIC_REGULATOR_EN, .CHAN_ENABLE, .HIGH_EFFICIENCY,
  .STEP_OUT_FLAG_N_OE_N, .WARNING_N_OE_N);

// file: verification/sdp_host_model.sv
module sdp_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // step request and step clock
  input wire logic run,
  output logic step,
  output int pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] ph_r;
  // one pulse per four cycles, a started period always completes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 2'h0;
      step <= 1'b0;
      pulses <= 0;
    end else if (run || ph_r != 2'h0) begin
      ph_r <= ph_r + 2'h1;
      step <= ph_r == 2'h0;
      pulses <= pulses + int'(ph_r == 2'h0);
    end
  end
endmodule

// file: verification/tb_stepper_driver_protection_status.sv
module tb_stepper_driver_protection_status;
  timeunit 1ns;
  timeprecision 1ps;
  import sdp_pkg::*;
  logic mclk = 1'b0, resetn = 1'b0, ca = 1'b0, dts = 1'b0, eme = 1'b0, run = 1'b0;
  logic mso = 1'b0, gbr = 1'b0, tt = 1'b0, sod = 1'b0, step;
  logic [1:0] sd = 2'h0, cso = 2'h0, en, pos;
  logic cpe, lre, he, br, so_o, so_oe_n, w_o, w_oe_n;
  logic signed [7:0] l1, l2;
  logic [31:0] rnd = 32'hCBEE;
  int mismatches = 0, check_count = 0, pulses, exp_pos = 0;
  // open-drain flags with pull-up
  wire so_n = so_oe_n ? 1'b1 : so_o;
  wire warn_n = w_oe_n ? 1'b1 : w_o;
  sdp_top #(.BOOST_SETTLE_CYC(10)) sdp_top_inst (.MCLK(mclk), .RESETN(resetn), .CHIP_ACTIVE(ca),
    .DRIVE_TYPE_SELECT(dts), .EFFICIENCY_MODE_ENABLE(eme), .STEP(step), .MOTOR_SUPPLY_OK(mso),
    .GATE_BOOST_RAIL_OK(gbr), .THERMAL_TRIP(tt), .STEP_OUT_DETECT(sod), .SHORT_DETECT(sd),
    .CURRENT_SENSE_NODE_OPEN(cso), .CHARGE_PUMP_EN(cpe), .LOGIC_REGULATOR_EN(lre), .CHAN_ENABLE(en),
    .CHAN1_LEVEL(l1), .CHAN2_LEVEL(l2), .EXCITE_POS(pos), .HIGH_EFFICIENCY(he), .BOOST_READY(br),
    .STEP_OUT_FLAG_N_O(so_o), .STEP_OUT_FLAG_N_OE_N(so_oe_n), .WARNING_N_O(w_o), .WARNING_N_OE_N(w_oe_n));
  sdp_host_model sdp_host_model_inst (.clk(mclk), .rst_n(resetn), .run(run), .step(step), .pulses(pulses));
  always #5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  task w(int n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(string nm, logic [15:0] s, logic [15:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  function logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected drive view from the model position
  task chk_run();
    int p;
    p = exp_pos % 4;
    chk("en", en, 16'h3);
    chk("lvl", {l1, l2}, {(p < 2) ? SDP_LEVEL_POS_FULL : SDP_LEVEL_NEG_FULL,
      (p == 1 || p == 2) ? SDP_LEVEL_POS_FULL : SDP_LEVEL_NEG_FULL});
    chk("pos", pos, 16'(p));
  endtask
  task steps(int n);
    int t;
    t = pulses + n;
    @(posedge mclk) run <= 1'b1;
    while (pulses < t) @(negedge mclk);
    @(posedge mclk) run <= 1'b0;
    w(6);
    exp_pos += n;
  endtask
  task print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    w(2);
    chk("idle", {en, so_n, warn_n}, 16'h3);
    @(posedge mclk) mso <= 1'b1;
    gbr <= 1'b1;
    w(1);
    chk("sup", {cpe, lre}, 16'h0);
    @(posedge mclk) ca <= 1'b1;
    w(1);
    chk("sup", {cpe, lre}, 16'h3);
    chk("br", br, 16'h0);
    w(12);
    chk("br", br, 16'h1);
    chk_run();
    rnd = lfsr(rnd);
    steps(1 + int'(rnd[2:0]));
    chk_run();
    @(posedge mclk) eme <= 1'b1;
    sod <= 1'b1;
    @(posedge mclk) sod <= 1'b0;
    w(2);
    chk("so", so_n, 16'h0);
    steps(1);
    chk("so", so_n, 16'h1);
    @(posedge mclk) eme <= 1'b0;
    sod <= 1'b1;
    @(posedge mclk) sod <= 1'b0;
    w(2);
    chk("so", so_n, 16'h1);
    @(posedge mclk) tt <= 1'b1;
    w(2);
    chk("tsd", {en, warn_n}, 16'h0);
    @(posedge mclk) tt <= 1'b0;
    w(6);
    chk("tsd", {en, warn_n}, 16'h7);
    rnd = lfsr(rnd);
    @(posedge mclk) sd <= rnd[0] ? 2'h1 : 2'h2;
    @(posedge mclk) sd <= 2'h0;
    w(4);
    chk("sc", {en, warn_n}, 16'h0);
    w(8);
    chk("sc", {en, warn_n}, 16'h0);
    @(posedge mclk) ca <= 1'b0;
    w(2);
    @(posedge mclk) ca <= 1'b1;
    w(14);
    exp_pos = 0;
    chk_run();
    chk("sc", warn_n, 16'h1);
    @(posedge mclk) dts <= 1'b1;
    cso <= 2'h1;
    w(4);
    chk("dc", en, 16'h2);
    print_verdict();
  end
endmodule
